// ===== verilog/msi_capability_block.sv
// Contract
// - control upper byte reads zero, ignores writes
// - control bit 7 reads constant one
// - granted count holds codes 000 to 101
// - requested count reads constant 000
// - messages only while enable bit is set
// - low address bits 1:0 read zero
// - zero upper address means 32-bit header
// - message writes programmed payload to address
// - payload bits 15:4 sent unaltered
// - payload bits 3:0 sent unaltered
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"

module msi_capability_block
  import msi_cap_pkg::*;
(
  input wire logic i_mclk, // core clock, 25 MHz
  input wire logic i_rst, // async reset, active high
  input wire logic i_ce, // clock enable, freezes all state
  input wire cfg_access_t i_cfg, // configuration access request
  output logic o_cfg_ack, // access answered, one-cycle pulse
  output logic [31:0] o_cfg_rdata, // read data, valid with ack
  input wire logic i_irq_event, // interrupt event, one-cycle pulse
  output logic o_msg_valid, // message write offered upstream
  output msg_write_t o_msg, // message write header and payload
  input wire logic i_msg_ready // upstream takes the message
);

  // dword indices of the words holding each register
  localparam logic [5:0] DW_CTL = 6'((`CAP_CTL_OFF) >> 2);
  localparam logic [5:0] DW_LO = 6'((`CAP_ADDR_LO_OFF) >> 2);
  localparam logic [5:0] DW_HI = 6'((`CAP_ADDR_HI_OFF) >> 2);
  localparam logic [5:0] DW_DATA = 6'((`CAP_DATA_OFF) >> 2);
  // reset words held as typed constants so their fields can be sliced
  localparam logic [15:0] CTL_RST = `CAP_CTL_RST;
  localparam logic [31:0] ADDR_RST = `CAP_ADDR_RST;

  // software-visible state
  logic en_reg; // enable bit
  logic en_next;
  logic [2:0] cnt_reg; // granted vector count code
  logic [2:0] cnt_next;
  logic [31:`ADDR_LSB] lo_reg; // stored low address bits
  logic [31:`ADDR_LSB] lo_next;
  logic [31:0] hi_reg; // upper address word
  logic [31:0] hi_next;
  logic [15:0] data_reg; // message payload
  logic [15:0] data_next;

  // access answer
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // message launcher
  msg_state_t state_reg;
  msg_state_t state_next;
  logic pend_reg; // an event waits for launch
  logic pend_next;
  msg_write_t msg_reg;
  msg_write_t msg_next;
  logic valid_reg; // offer flag, its own flop so the pin is glitch free
  logic valid_next;

  // decoded access
  logic [5:0] dw_sel; // dword index of the access
  logic wr_hit; // write strobe this cycle
  logic [15:0] ctl_view; // control register as read
  logic [31:0] lo_view; // low address as read
  logic launch; // message leaves the idle state
  logic [31:0] lo_merged; // low address after byte merge
  logic [31:0] hi_merged; // upper address after byte merge
  logic [31:0] data_merged; // payload word after byte merge

  // byte-lane merge shared by the address and payload words
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // decode and the read-side views of the registers
  always_comb
  begin
    dw_sel = i_cfg.offset[7:2];
    wr_hit = i_cfg.valid && i_cfg.write;
    // reserved byte and fixed fields are constants here, never flops
    ctl_view = {8'h00, 1'b1, cnt_reg, `REQ_CODE, en_reg};
    lo_view = {lo_reg, 2'b00};
    lo_merged = merge_bytes(lo_view, i_cfg.wdata, i_cfg.byte_en);
    hi_merged = merge_bytes(hi_reg, i_cfg.wdata, i_cfg.byte_en);
    data_merged = merge_bytes({16'h0000, data_reg}, i_cfg.wdata,
      i_cfg.byte_en);
  end

  // register writes; control sits in lanes 3:2 of its dword
  always_comb
  begin
    en_next = en_reg;
    cnt_next = cnt_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    data_next = data_reg;
    if (wr_hit)
    begin
      unique case (dw_sel)
        DW_CTL:
        begin
          // lane 3 is the reserved byte: its enable is dropped
          if (i_cfg.byte_en[2])
          begin
            en_next = i_cfg.wdata[16 + `CTL_EN_BIT];
            // a reserved code keeps the old count, so it stays legal
            if (i_cfg.wdata[16 + `CTL_CNT_MSB:16 + `CTL_CNT_LSB]
                <= `CNT_MAX)
            begin
              cnt_next =
                i_cfg.wdata[16 + `CTL_CNT_MSB:16 + `CTL_CNT_LSB];
            end
          end
        end
        DW_LO:
        begin
          // bits 1:0 are never stored
          lo_next = lo_merged[31:`ADDR_LSB];
        end
        DW_HI:
        begin
          hi_next = hi_merged;
        end
        DW_DATA:
        begin
          // upper half of this dword holds no register
          data_next = data_merged[15:0];
        end
        default:
        begin
          // unmapped dword: write ignored
        end
      endcase
    end
  end

  // read answer, one cycle after every access
  always_comb
  begin
    ack_next = i_cfg.valid;
    rdata_next = rdata_reg;
    if (i_cfg.valid)
    begin
      unique case (dw_sel)
        DW_CTL:
        begin
          // low half belongs to the id and pointer, read as zero
          rdata_next = {ctl_view, 16'h0000};
        end
        DW_LO:
        begin
          rdata_next = lo_view;
        end
        DW_HI:
        begin
          rdata_next = hi_reg;
        end
        DW_DATA:
        begin
          rdata_next = {16'h0000, data_reg};
        end
        default:
        begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // launcher: events merge while one waits, at most one in flight
  always_comb
  begin
    state_next = state_reg;
    msg_next = msg_reg;
    launch = (state_reg == ST_IDLE) && pend_reg && en_next;
    // a new event wins over the clear made by a launch
    pend_next = (pend_reg && !launch) || (i_irq_event && en_reg);
    if (!en_next)
    begin
      // disabling drops waiting events as well
      pend_next = 1'b0;
    end
    unique case (state_reg)
      ST_IDLE:
      begin
        if (launch)
        begin
          state_next = ST_SEND;
          msg_next.hdr_4dw = (hi_reg != 32'h0000_0000);
          msg_next.addr = {hi_reg, lo_reg, 2'b00};
          // the index bits go out as written, no vector is merged in
          msg_next.data = data_reg;
        end
      end
      ST_SEND:
      begin
        // withdrawn at once if software disables signalling
        if (i_msg_ready || !en_next)
        begin
          state_next = ST_IDLE;
        end
      end
    endcase
    // mirrors the send state one to one
    valid_next = (state_next == ST_SEND);
  end

  // register stage for all state; frozen while i_ce is low
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_reg <= CTL_RST[`CTL_EN_BIT];
      cnt_reg <= CTL_RST[`CTL_CNT_MSB:`CTL_CNT_LSB];
      lo_reg <= ADDR_RST[31:`ADDR_LSB];
      hi_reg <= `CAP_ADDR_RST;
      data_reg <= `CAP_DATA_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      state_reg <= ST_IDLE;
      valid_reg <= 1'b0;
      pend_reg <= 1'b0;
      msg_reg <= '0;
    end
    else if (i_ce)
    begin
      en_reg <= en_next;
      cnt_reg <= cnt_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      data_reg <= data_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      valid_reg <= valid_next;
      pend_reg <= pend_next;
      msg_reg <= msg_next;
    end
  end

  // outputs straight from flops
  assign o_cfg_ack = ack_reg;
  assign o_cfg_rdata = rdata_reg;
  assign o_msg_valid = valid_reg;
  assign o_msg = msg_reg;

  // checks next to the logic
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  ctl_upper_zero_a: assert property (
    o_cfg_ack && $past(i_cfg.offset[7:2]) == DW_CTL
      |-> o_cfg_rdata[31:24] == 8'h00)
    else $error("control upper byte not zero");

  wide_cap_one_a: assert property (
    o_cfg_ack && $past(i_cfg.offset[7:2]) == DW_CTL
      |-> o_cfg_rdata[16 + `CTL_WIDE_BIT] == 1'b1)
    else $error("wide address bit not constant one");

  count_legal_a: assert property (
    cnt_reg <= `CNT_MAX)
    else $error("granted count holds reserved code");

  req_count_zero_a: assert property (
    o_cfg_ack && $past(i_cfg.offset[7:2]) == DW_CTL
      |-> o_cfg_rdata[16 + `CTL_REQ_MSB:16 + `CTL_REQ_LSB] == 3'h0)
    else $error("requested count not zero");

  msg_needs_enable_a: assert property (
    o_msg_valid |-> en_reg)
    else $error("message offered while disabled");

  addr_aligned_a: assert property (
    (o_cfg_ack && $past(i_cfg.offset[7:2]) == DW_LO
      |-> o_cfg_rdata[1:0] == 2'b00)
    and (o_msg_valid |-> o_msg.addr[1:0] == 2'b00))
    else $error("message address not dword aligned");

  header_select_a: assert property (
    o_msg_valid |-> o_msg.hdr_4dw == (o_msg.addr[63:32] != 32'h0))
    else $error("header size does not match upper address");

  payload_fixed_a: assert property (
    $rose(o_msg_valid)
      |-> o_msg.data[15:4] == $past(data_reg[15:4])
        && o_msg.addr == $past({hi_reg, lo_view}))
    else $error("payload or address differs from programmed");

  index_unchanged_a: assert property (
    $rose(o_msg_valid)
      |-> o_msg.data[`DATA_IDX_MSB:0] == $past(data_reg[3:0]))
    else $error("vector index bits altered");

  one_write_a: assert property (
    o_msg_valid && i_msg_ready && i_ce |=> !o_msg_valid)
    else $error("second write for one event");

  event_to_msg_a: assert property (
    (i_ce && i_irq_event && en_reg && !o_msg_valid && !pend_reg
      && !i_cfg.valid) ##1 (i_ce && !i_cfg.valid) |=> o_msg_valid)
    else $error("enabled event did not launch a write");

  short_msg_c: cover property (
    o_msg_valid && i_msg_ready && !o_msg.hdr_4dw);
  long_msg_c: cover property (
    o_msg_valid && i_msg_ready && o_msg.hdr_4dw);
  stalled_msg_c: cover property (
    o_msg_valid && !i_msg_ready ##1 o_msg_valid && i_msg_ready);
  event_disabled_c: cover property (i_irq_event && !en_reg);

endmodule

// ===== pkg/msi_cap_cfg.svh
`ifndef MSI_CAP_CFG_SVH
`define MSI_CAP_CFG_SVH

// configuration-space byte offsets of the capability registers
`define CAP_CTL_OFF 8'h72
`define CAP_ADDR_LO_OFF 8'h74
`define CAP_ADDR_HI_OFF 8'h78
`define CAP_DATA_OFF 8'h7c

// reset values
`define CAP_CTL_RST 16'h0080
`define CAP_ADDR_RST 32'h0000_0000
`define CAP_DATA_RST 16'h0000

// control register field positions
`define CTL_RSVD_MSB 15
`define CTL_RSVD_LSB 8
`define CTL_WIDE_BIT 7
`define CTL_CNT_MSB 6
`define CTL_CNT_LSB 4
`define CTL_REQ_MSB 3
`define CTL_REQ_LSB 1
`define CTL_EN_BIT 0

// largest legal granted-count code (thirty-two vectors)
`define CNT_MAX 3'h5
// requested-count code: a single vector only
`define REQ_CODE 3'h0
// lowest stored bit of the low address word
`define ADDR_LSB 2
// top bit of the vector index part of the payload
`define DATA_IDX_MSB 3

`endif

// ===== pkg/msi_cap_pkg.sv
package msi_cap_pkg;

  // one configuration access, dword aligned, with byte enables
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_access_t;

  // one posted memory write carrying the interrupt message
  typedef struct packed {
    logic hdr_4dw;
    logic [63:0] addr;
    logic [15:0] data;
  } msg_write_t;

  // message launcher states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } msg_state_t;

endpackage

// ===== tb/msg_sink_model.sv
`timescale 1ns/1ps

// upstream receiver of interrupt message writes, with a settable stall
module msg_sink_model
  import msi_cap_pkg::*;
(
  input wire logic i_mclk, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_msg_valid, // message write offered
  input wire msg_write_t i_msg, // offered header and payload
  input wire logic [31:0] i_stall, // cycles to hold off before ready
  output logic o_msg_ready, // this side takes the message
  output msg_write_t o_last, // last message taken
  output int o_count // number of messages taken
);
  int wait_reg; // cycles the current offer has waited

  // take one write per offer, ready only after the stall has run out
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_msg_ready <= 1'b0;
      wait_reg <= 0;
      o_count <= 0;
      o_last <= '0;
    end
    else if (i_msg_valid && o_msg_ready)
    begin
      // ready drops at once so a second offer is never taken blind
      o_count <= o_count + 1;
      o_last <= i_msg;
      o_msg_ready <= 1'b0;
      wait_reg <= 0;
    end
    else if (i_msg_valid)
    begin
      wait_reg <= wait_reg + 1;
      o_msg_ready <= (wait_reg >= i_stall);
    end
    else
    begin
      // withdrawn offer restarts the stall count
      o_msg_ready <= 1'b0;
      wait_reg <= 0;
    end
  end
endmodule

// ===== tb/msi_capability_block_tb.sv
`timescale 1ns/1ps
`include "msi_cap_cfg.svh"

module msi_capability_block_tb
  import msi_cap_pkg::*;
();
  logic i_mclk = 1'b0; // 25 MHz core clock
  logic i_rst = 1'b1; // reset held at start
  logic i_ce = 1'b1; // clock enable left running
  logic i_irq_event = 1'b0; // interrupt event pulse
  cfg_access_t i_cfg = '0; // configuration request
  logic o_cfg_ack; // access answered
  logic [31:0] o_cfg_rdata; // read data
  logic o_msg_valid; // message offered
  logic i_msg_ready; // receiver takes it
  msg_write_t o_msg; // offered message
  msg_write_t last_msg; // last message taken
  int n_msgs; // messages taken so far
  int stall = 0; // receiver hold-off
  int n_fail = 0; // mismatches
  int n_compared = 0; // comparisons made

  always #20 i_mclk = ~i_mclk;

  msi_capability_block i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
    .i_cfg(i_cfg), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_irq_event(i_irq_event), .o_msg_valid(o_msg_valid), .o_msg(o_msg),
    .i_msg_ready(i_msg_ready));

  msg_sink_model i_sink (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_msg_valid(o_msg_valid), .i_msg(o_msg), .i_stall(stall),
    .o_msg_ready(i_msg_ready), .o_last(last_msg), .o_count(n_msgs));

  // verdict and end of run, also used when a wait runs out
  task stop_test();
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // one access; ack and read data stand for the cycle after the taking
  // edge, so both are looked at on the falling edge inside that cycle
  task cfg(input logic wr, input logic [7:0] off, input logic [31:0] wd,
           output logic [31:0] rd);
    @(negedge i_mclk);
    i_cfg <= '{1'b1, wr, off, 4'hf, wd};
    @(negedge i_mclk);
    chk(64'(o_cfg_ack), 64'h1, "config ack");
    rd = o_cfg_rdata;
    i_cfg.valid <= 1'b0;
  endtask

  task wr(input logic [7:0] off, input logic [31:0] wd);
    logic [31:0] r;
    cfg(1'b1, off, wd, r);
  endtask

  task rd_chk(input logic [7:0] off, input logic [31:0] exp, input string s);
    logic [31:0] r;
    cfg(1'b0, off, 32'h0, r);
    chk(64'(r), 64'(exp), s);
  endtask

  // pulse one event, then wait bounded for the expected message count
  task fire(input int n_exp);
    int k;
    @(negedge i_mclk);
    i_irq_event <= 1'b1;
    @(negedge i_mclk);
    i_irq_event <= 1'b0;
    k = 0;
    while (n_msgs != n_exp && k < 40)
    begin
      @(negedge i_mclk);
      k++;
    end
    if (n_msgs != n_exp)
    begin
      n_fail++;
      $display("wrong value at %0t: message count", $time);
      stop_test();
    end
  endtask

  task t_reset();
    rd_chk(`CAP_CTL_OFF, 32'h0080_0000, "control reset");
    rd_chk(`CAP_ADDR_LO_OFF, 32'h0, "low address reset");
    rd_chk(`CAP_ADDR_HI_OFF, 32'h0, "high address reset");
    rd_chk(`CAP_DATA_OFF, 32'h0, "payload reset");
    $display("reset values done");
  endtask

  task t_control();
    wr(`CAP_CTL_OFF, 32'hffff_ffff);
    rd_chk(`CAP_CTL_OFF, 32'h0081_0000, "all ones");
    wr(`CAP_CTL_OFF, 32'h0051_0000);
    rd_chk(`CAP_CTL_OFF, 32'h00d1_0000, "count 101");
    wr(`CAP_CTL_OFF, 32'h0061_0000);
    rd_chk(`CAP_CTL_OFF, 32'h00d1_0000, "count 110");
    $display("control register done");
  endtask

  task t_address();
    wr(`CAP_ADDR_LO_OFF, 32'hffff_ffff);
    rd_chk(`CAP_ADDR_LO_OFF, 32'hffff_fffc, "low address");
    wr(`CAP_ADDR_HI_OFF, 32'hffff_ffff);
    rd_chk(`CAP_ADDR_HI_OFF, 32'hffff_ffff, "high address");
    $display("address registers done");
  endtask

  // short header, prompt receiver, every payload bit carried through
  task t_msg32();
    wr(`CAP_ADDR_HI_OFF, 32'h0);
    wr(`CAP_ADDR_LO_OFF, 32'h1234_567b);
    wr(`CAP_DATA_OFF, 32'hffff_abcd);
    rd_chk(`CAP_DATA_OFF, 32'h0000_abcd, "payload");
    fire(n_msgs + 1);
    chk(64'(last_msg.hdr_4dw), 64'h0, "short header");
    chk(last_msg.addr, 64'h1234_5678, "short address");
    chk(64'(last_msg.data), 64'habcd, "message payload");
    $display("short message done");
  endtask

  // long header, slow receiver, exactly one write per event
  task t_msg64();
    int n0;
    stall = 5;
    wr(`CAP_ADDR_HI_OFF, 32'h0000_0001);
    n0 = n_msgs;
    fire(n0 + 1);
    chk(64'(last_msg.hdr_4dw), 64'h1, "long header");
    chk(last_msg.addr, 64'h1_1234_5678, "long address");
    repeat (12) @(negedge i_mclk);
    chk(64'(n_msgs), 64'(n0 + 1), "one write");
    stall = 0;
    $display("long message done");
  endtask

  // with the enable cleared an event must not leave the block
  task t_disabled();
    int n0;
    wr(`CAP_CTL_OFF, 32'h0050_0000);
    n0 = n_msgs;
    @(negedge i_mclk);
    i_irq_event <= 1'b1;
    @(negedge i_mclk);
    i_irq_event <= 1'b0;
    repeat (12) @(negedge i_mclk);
    chk(64'(n_msgs), 64'(n0), "disabled event");
    $display("disabled event done");
  endtask

  initial
  begin
    repeat (20) @(negedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_control();
    t_address();
    t_msg32();
    t_msg64();
    t_disabled();
    stop_test();
  end
endmodule
